/* File: rtl/nsi_interrupt_unit.sv */
/*
 * Nine source interrupt unit with an AXI4-Lite register slave.
 * Assumes timer and conversion events come from logic on aclk, the three
 * external interrupt pins are asynchronous, and the core pulses
 * instr_boundary between instructions and return_from_interrupt on return.
 */
`timescale 1ns/1ps

// Overview of operation
// - Accepting an interrupt clears the global enable bit.
// - Return from interrupt sets the global enable bit back to one.
// - Accepting pushes one stack level and loads program counter with 8.
// - Working and flag registers saved on entry, restored on return.
// - Low enable register: pins 0-2 in bits 0-2, timers and ADC in 4-7.
// - High enable register: timer 2 in bit 0, timer 3 in bit 1.
// - An enable bit of one enables that source, zero disables it.
// - A source event sets its request flag, which stays set.
// - Low request register uses the low enable register bit layout.
// - High request register: timer 2 in bit 0, timer 3 in bit 1.
// - Global enable is stack register bit 7, resets to 0, gates service.
// - A selected pin edge sets its flag only while the pin is enabled.
// - Edge select: pin 0 bits 1:0, pin 1 bits 3:2, pin 2 bits 5:4.
// - Edge codes: 01 rising, 10 falling, 11 both, 00 reserved.
// - A matching pin edge during sleep is latched and serviced first.
// - An external pin event wakes the chip from power-down.
// - Internal events set their flags whatever the enable bits are.
module nsi_interrupt_unit (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [11:0]         awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [11:0]         araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire nsi_pkg::nsi_evt_t   source_events,
    input  wire logic [2:0]          external_pin,
    input  wire logic                sleep_mode,
    input  wire logic                instr_boundary,
    input  wire logic                return_from_interrupt,
    input  wire nsi_pkg::nsi_ctx_t   core_ctx,
    output logic                     vector_load_q,
    output logic [10:0]              pc_vector_q,
    output logic                     restore_q,
    output nsi_pkg::nsi_ctx_t        restored_ctx_q,
    output logic                     wake_request_q,
    output logic                     in_service_q
);

    // Bus side state
    logic [11:0]          awaddr_q;
    logic [7:0]           wdata_q;
    logic                 wstrb0_q;
    // Register contents
    logic [7:0]           edge_sel_q;
    logic [7:0]           flags_low_q;
    logic [7:0]           flags_high_q;
    logic [7:0]           enable_low_q;
    logic [7:0]           enable_high_q;
    logic                 gie_q;
    logic [2:0]           stack_level_q;
    // Pin sampling and wake-up latch
    logic [2:0]           pin_s1_q;
    logic [2:0]           pin_s2_q;
    logic [2:0]           pin_s3_q;
    logic [2:0]           wake_latch_q;
    logic                 sleep_prev_q;
    nsi_pkg::nsi_state_t  state_q;
    nsi_pkg::nsi_ctx_t    saved_ctx_q;
    // Combinational terms
    logic [2:0]           pin_match;
    logic [2:0]           pin_set;
    logic [7:0]           set_low;
    logic [7:0]           set_high;
    logic                 wr_fire;
    logic                 b_done;
    nsi_pkg::nsi_sel_t    wr_sel;
    logic                 wr_en;
    logic                 sleep_exit;
    logic                 pending;
    logic                 accept;
    logic                 leave;

    // Address to register; used by both the write and the read path
    function automatic nsi_pkg::nsi_sel_t decode(input logic [11:0] addr);
        nsi_pkg::nsi_sel_t sel;
        sel = nsi_pkg::NSI_SEL_NONE;
        if (addr[1:0] != 2'h0)
            sel = nsi_pkg::NSI_SEL_NONE;
        else if (addr[11:2] == {2'h0, nsi_pkg::IDX_PIN_EDGE})
            sel = nsi_pkg::NSI_SEL_EDGE;
        else if (addr[11:2] == {2'h0, nsi_pkg::IDX_RQ_HIGH})
            sel = nsi_pkg::NSI_SEL_RQH;
        else if (addr[11:2] == {2'h0, nsi_pkg::IDX_EN_HIGH})
            sel = nsi_pkg::NSI_SEL_ENH;
        else if (addr[11:2] == {2'h0, nsi_pkg::IDX_RQ_LOW})
            sel = nsi_pkg::NSI_SEL_RQL;
        else if (addr[11:2] == {2'h0, nsi_pkg::IDX_EN_LOW})
            sel = nsi_pkg::NSI_SEL_ENL;
        else if (addr[11:2] == {2'h0, nsi_pkg::IDX_STACK_LEVEL})
            sel = nsi_pkg::NSI_SEL_STACK;
        return sel;
    endfunction : decode

    // Edge code against the seen edges; the reserved code matches nothing
    function automatic logic edge_match(input logic [1:0] code,
                                        input logic       rise,
                                        input logic       fall);
        case (code)
            nsi_pkg::EDGE_RISE: return rise;
            nsi_pkg::EDGE_FALL: return fall;
            nsi_pkg::EDGE_BOTH: return rise | fall;
            default:            return 1'b0;
        endcase
    endfunction : edge_match

    // Write path terms; a channel counts as held while its ready is low
    assign wr_fire = ~awready & ~wready & ~bvalid;
    assign b_done  = bvalid & bready;
    assign wr_sel  = decode(awaddr_q);
    assign wr_en   = wr_fire & wstrb0_q & (wr_sel != nsi_pkg::NSI_SEL_NONE);

    // Write address and data capture in either order; lane 0 only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready  <= 1'b1;
            wready   <= 1'b1;
            awaddr_q <= 12'h000;
            wdata_q  <= 8'h00;
            wstrb0_q <= 1'b0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awready  <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                wready   <= 1'b0;
                wdata_q  <= wdata[7:0];
                wstrb0_q <= wstrb[0];
            end
            if (b_done)
            begin
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= nsi_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            bresp  <= (wr_sel == nsi_pkg::NSI_SEL_NONE) ? nsi_pkg::RESP_SLVERR
                                                        : nsi_pkg::RESP_OKAY;
        end
        else if (b_done)
            bvalid <= 1'b0;
    end

    // Read channel; data one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= nsi_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= nsi_pkg::RESP_OKAY;
            rdata   <= 32'h0000_0000;
            case (decode(araddr))
                nsi_pkg::NSI_SEL_EDGE:  rdata[7:0] <= edge_sel_q;
                nsi_pkg::NSI_SEL_RQH:   rdata[7:0] <= flags_high_q;
                nsi_pkg::NSI_SEL_ENH:   rdata[7:0] <= enable_high_q;
                nsi_pkg::NSI_SEL_RQL:   rdata[7:0] <= flags_low_q;
                nsi_pkg::NSI_SEL_ENL:   rdata[7:0] <= enable_low_q;
                nsi_pkg::NSI_SEL_STACK: rdata[7:0] <= {gie_q, 4'h0, stack_level_q};
                default:                rresp      <= nsi_pkg::RESP_SLVERR;
            endcase
        end
        else if (rvalid && rready)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    // Two-flop pin synchroniser plus a history stage for edges
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
        end
        else
        begin
            pin_s1_q <= external_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Per-pin edge detection against its edge field
    assign sleep_exit = sleep_prev_q & ~sleep_mode;
    for (genvar i = 0; i < nsi_pkg::PIN_COUNT; i++)
    begin : g_pin
        assign pin_match[i] = edge_match(edge_sel_q[2*i +: nsi_pkg::EDGE_FIELD_W],
                                         pin_s2_q[i] & ~pin_s3_q[i],
                                         ~pin_s2_q[i] & pin_s3_q[i]);
        // Awake: enabled edge sets flag; on wake-up the latched edge does
        assign pin_set[i] = (pin_match[i] & enable_low_q[i] & ~sleep_mode)
                          | (sleep_exit & wake_latch_q[i] & enable_low_q[i]);
    end

    // Edge latch across sleep and wake-up request
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_latch_q   <= 3'h0;
            sleep_prev_q   <= 1'b0;
            wake_request_q <= 1'b0;
        end
        else
        begin
            sleep_prev_q   <= sleep_mode;
            wake_request_q <= sleep_mode & (|pin_match);
            if (sleep_exit)
                wake_latch_q <= 3'h0;
            else if (sleep_mode)
                wake_latch_q <= wake_latch_q | pin_match;
        end
    end

    // Hardware set terms in register bit order
    always_comb
    begin
        set_low = 8'h00;
        set_low[2:0]                        = pin_set;
        set_low[nsi_pkg::POS_BASIC_TIMER]   = source_events.basic_timer_overflow;
        set_low[nsi_pkg::POS_TIMER0]        = source_events.timer0_overflow;
        set_low[nsi_pkg::POS_TIMER1]        = source_events.timer1_overflow;
        set_low[nsi_pkg::POS_CONVERSION]    = source_events.conversion_done;
        set_high = 8'h00;
        set_high[nsi_pkg::POS_TIMER2]       = source_events.timer2_overflow;
        set_high[nsi_pkg::POS_TIMER3]       = source_events.timer3_overflow;
    end

    // Request flags; a set in the cycle of a software clear wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags_low_q  <= nsi_pkg::RST_FLAGS;
            flags_high_q <= nsi_pkg::RST_FLAGS;
        end
        else
        begin
            flags_low_q <= (((wr_en && wr_sel == nsi_pkg::NSI_SEL_RQL) ? wdata_q : flags_low_q)
                           | set_low) & nsi_pkg::MASK_LOW;
            flags_high_q <= (((wr_en && wr_sel == nsi_pkg::NSI_SEL_RQH) ? wdata_q : flags_high_q)
                            | set_high) & nsi_pkg::MASK_HIGH;
        end
    end

    // Enable and edge select registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_low_q  <= nsi_pkg::RST_ENABLE;
            enable_high_q <= nsi_pkg::RST_ENABLE;
            edge_sel_q    <= nsi_pkg::RST_EDGE;
        end
        else if (wr_en)
        begin
            if (wr_sel == nsi_pkg::NSI_SEL_ENL)
                enable_low_q <= wdata_q & nsi_pkg::MASK_LOW;
            if (wr_sel == nsi_pkg::NSI_SEL_ENH)
                enable_high_q <= wdata_q & nsi_pkg::MASK_HIGH;
            if (wr_sel == nsi_pkg::NSI_SEL_EDGE)
                edge_sel_q <= wdata_q & nsi_pkg::MASK_EDGE;
        end
    end

    // Service decision at instruction boundaries
    assign pending = |(flags_low_q & enable_low_q) | |(flags_high_q & enable_high_q);
    assign accept  = instr_boundary & gie_q & pending & ~sleep_mode
                   & (state_q == nsi_pkg::NSI_ST_IDLE);
    assign leave   = return_from_interrupt & (state_q == nsi_pkg::NSI_ST_SERVICE);

    // Global enable and stack level; hardware beats a software write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gie_q         <= nsi_pkg::RST_GIE;
            stack_level_q <= nsi_pkg::RST_STACK_LEVEL;
        end
        else if (accept)
        begin
            gie_q         <= 1'b0;
            stack_level_q <= stack_level_q - 3'h1;
        end
        else if (leave)
        begin
            gie_q         <= 1'b1;
            stack_level_q <= stack_level_q + 3'h1;
        end
        else if (wr_en && wr_sel == nsi_pkg::NSI_SEL_STACK)
        begin
            gie_q         <= wdata_q[nsi_pkg::POS_GIE];
            stack_level_q <= wdata_q[2:0];
        end
    end

    // Service state machine
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= nsi_pkg::NSI_ST_IDLE;
        else
        begin
            case (state_q)
                nsi_pkg::NSI_ST_IDLE:
                    if (accept)
                        state_q <= nsi_pkg::NSI_ST_SERVICE;
                nsi_pkg::NSI_ST_SERVICE:
                    if (leave)
                        state_q <= nsi_pkg::NSI_ST_IDLE;
                default:
                    state_q <= nsi_pkg::NSI_ST_IDLE;
            endcase
        end
    end

    // Vector load, context save and restore toward the core
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            vector_load_q  <= 1'b0;
            pc_vector_q    <= 11'h000;
            restore_q      <= 1'b0;
            saved_ctx_q    <= '0;
            restored_ctx_q <= '0;
            in_service_q   <= 1'b0;
        end
        else
        begin
            vector_load_q <= accept;
            restore_q     <= leave;
            in_service_q  <= (state_q == nsi_pkg::NSI_ST_SERVICE) ? ~leave : accept;
            if (accept)
            begin
                pc_vector_q <= nsi_pkg::IRQ_VECTOR;
                saved_ctx_q <= core_ctx;
            end
            if (leave)
                restored_ctx_q <= saved_ctx_q;
        end
    end

endmodule : nsi_interrupt_unit

/* File: rtl/nsi_pkg.sv */
/*
 * Package of the nine source interrupt unit: register indices, field
 * positions, masks, reset values, edge codes and the carrier structs.
 * Assumes an 8-bit core with an 11-bit program counter.
 */
package nsi_pkg;

    // Register indices; the bus byte address is four times the index
    localparam logic [7:0]  IDX_PIN_EDGE    = 8'hbf;
    localparam logic [7:0]  IDX_RQ_HIGH     = 8'hc6;
    localparam logic [7:0]  IDX_EN_HIGH     = 8'hc7;
    localparam logic [7:0]  IDX_RQ_LOW      = 8'hc8;
    localparam logic [7:0]  IDX_EN_LOW      = 8'hc9;
    localparam logic [7:0]  IDX_STACK_LEVEL = 8'hdf;

    // Implemented bits of each register
    localparam logic [7:0]  MASK_LOW        = 8'hf7;
    localparam logic [7:0]  MASK_HIGH       = 8'h03;
    localparam logic [7:0]  MASK_EDGE       = 8'h3f;

    // Reset values
    localparam logic [7:0]  RST_EDGE        = 8'h00;
    localparam logic [7:0]  RST_FLAGS       = 8'h00;
    localparam logic [7:0]  RST_ENABLE      = 8'h00;
    localparam logic        RST_GIE         = 1'b0;
    localparam logic [2:0]  RST_STACK_LEVEL = 3'h7;

    // Field positions
    localparam int          POS_BASIC_TIMER = 4;
    localparam int          POS_TIMER0      = 5;
    localparam int          POS_TIMER1      = 6;
    localparam int          POS_CONVERSION  = 7;
    localparam int          POS_TIMER2      = 0;
    localparam int          POS_TIMER3      = 1;
    localparam int          POS_GIE         = 7;
    localparam int          EDGE_FIELD_W    = 2;
    localparam int          PIN_COUNT       = 3;

    // Edge field codes
    localparam logic [1:0]  EDGE_NONE       = 2'h0;
    localparam logic [1:0]  EDGE_RISE       = 2'h1;
    localparam logic [1:0]  EDGE_FALL       = 2'h2;
    localparam logic [1:0]  EDGE_BOTH       = 2'h3;

    // Interrupt vector and bus answers
    localparam logic [10:0] IRQ_VECTOR      = 11'h008;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Register selected by an address
    typedef enum logic [2:0] {
        NSI_SEL_NONE  = 3'h0,
        NSI_SEL_EDGE  = 3'h1,
        NSI_SEL_RQH   = 3'h2,
        NSI_SEL_ENH   = 3'h3,
        NSI_SEL_RQL   = 3'h4,
        NSI_SEL_ENL   = 3'h5,
        NSI_SEL_STACK = 3'h6
    } nsi_sel_t;

    // Service state, Gray coded
    typedef enum logic [1:0] {
        NSI_ST_IDLE    = 2'b00,
        NSI_ST_SERVICE = 2'b01
    } nsi_state_t;

    // One-cycle overflow and conversion-end events
    typedef struct packed {
        logic conversion_done;
        logic timer3_overflow;
        logic timer2_overflow;
        logic timer1_overflow;
        logic timer0_overflow;
        logic basic_timer_overflow;
    } nsi_evt_t;

    // Core context saved on entry and restored on return
    typedef struct packed {
        logic [7:0] working_register;
        logic [7:0] program_status_flags;
    } nsi_ctx_t;

endpackage : nsi_pkg

/* File: tb/nsi_checker.sv */
/* Checker on the core side of the interrupt unit.
   Assumes it is bound into nsi_interrupt_unit, one clock, aclk. */
`timescale 1ns/1ps
module nsi_checker (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              instr_boundary,
    input  wire logic              return_from_interrupt,
    input  wire nsi_pkg::nsi_ctx_t core_ctx,
    input  wire logic              vector_load_q,
    input  wire logic [10:0]       pc_vector_q,
    input  wire logic              restore_q,
    input  wire nsi_pkg::nsi_ctx_t restored_ctx_q,
    input  wire logic              wake_request_q,
    input  wire logic              in_service_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    nsi_pkg::nsi_ctx_t             ctx_q;
    // Context offered at the accepting edge
    always_ff @(posedge aclk)
    begin
        if (vector_load_q)
        begin
            ctx_q <= $past(core_ctx);
        end
    end
    // Entry, nesting, return and context
    AST_VECTOR_ADDR: assert property (vector_load_q |-> pc_vector_q == nsi_pkg::IRQ_VECTOR)
        else $error("vector load without address 8");
    AST_VECTOR_PULSE: assert property (vector_load_q |=> !vector_load_q)
        else $error("vector load longer than one cycle");
    AST_ENTRY_CAUSE: assert property ($rose(in_service_q) |-> vector_load_q && $past(instr_boundary))
        else $error("service entered off an instruction boundary");
    AST_NO_NESTING: assert property (in_service_q && $past(in_service_q) |-> !vector_load_q)
        else $error("nested entry while in service");
    AST_SERVICE_SPAN: assert property (vector_load_q |-> in_service_q)
        else $error("vector load outside service");
    AST_RETURN: assert property (in_service_q && return_from_interrupt |=> restore_q && !in_service_q)
        else $error("return did not leave service");
    AST_IDLE_RETURN: assert property (!in_service_q |=> !restore_q)
        else $error("restore outside service");
    AST_CTX_BACK: assert property (restore_q |-> restored_ctx_q == ctx_q)
        else $error("restored context differs from saved one");
    COV_ENTRY: cover property (vector_load_q);
    COV_RETURN: cover property (restore_q);
    COV_WAKE: cover property (wake_request_q);
endmodule : nsi_checker

bind nsi_interrupt_unit nsi_checker u_checker (.aclk, .aresetn, .instr_boundary,
    .return_from_interrupt, .core_ctx, .vector_load_q, .pc_vector_q, .restore_q,
    .restored_ctx_q, .wake_request_q, .in_service_q);

/* File: tb/nsi_core_model.sv */
/* Behavioural core: instruction boundaries, a moving context and one
   return per accepted interrupt. Assumes the bench drives hold. */
`timescale 1ns/1ps
module nsi_core_model (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         hold,
    input  wire logic         vector_load_q,
    output logic              instr_boundary,
    output logic              return_from_interrupt,
    output nsi_pkg::nsi_ctx_t core_ctx
);
    logic                     pending_q;
    // Boundary every other cycle; return held back while hold is high
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_boundary        <= 1'b0;
            return_from_interrupt <= 1'b0;
            pending_q             <= 1'b0;
            core_ctx              <= 16'h0000;
        end
        else
        begin
            instr_boundary        <= ~instr_boundary;
            core_ctx              <= core_ctx + 16'h0135;
            return_from_interrupt <= pending_q & ~hold;
            pending_q             <= vector_load_q | (pending_q & hold);
        end
    end
endmodule : nsi_core_model

/* File: tb/test_nine_source_interrupt_unit.sv */
/* Bench of the interrupt unit: map, flags, pin edges, wake and service.
   Assumes a 40 MHz aclk and the core model on the core side. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_nine_source_interrupt_unit;
    logic              aclk = 1'b0, aresetn = 1'b0, hold = 1'b0, sleep_mode = 1'b0;
    logic [11:0]       awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata;
    logic [3:0]        wstrb = 4'hf;
    logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic              awready, wready, bvalid, arready, rvalid, restore_q, in_service_q;
    logic [1:0]        bresp, rresp;
    nsi_pkg::nsi_evt_t source_events = '0;
    logic [2:0]        external_pin = '0;
    logic              instr_boundary, return_from_interrupt, vector_load_q, wake_request_q;
    logic [10:0]       pc_vector_q;
    nsi_pkg::nsi_ctx_t core_ctx, restored_ctx_q;
    int                num_errors = 0, comparisons = 0, cycles = 0, wakes = 0;
    always #12.5 aclk = ~aclk;
    nsi_interrupt_unit dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .source_events, .external_pin, .sleep_mode,
        .instr_boundary, .return_from_interrupt, .core_ctx, .vector_load_q, .pc_vector_q,
        .restore_q, .restored_ctx_q, .wake_request_q, .in_service_q);
    nsi_core_model core (.aclk, .aresetn, .hold, .vector_load_q, .instr_boundary,
        .return_from_interrupt, .core_ctx);
    // Cycle ceiling and wake pulse count
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (wake_request_q) wakes <= wakes + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    // Register write, response checked
    task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= {2'h0, ix, 2'h0};
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
    endtask : wr
    // Register read, data and response checked
    task automatic rd(input logic [7:0] ix, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= {2'h0, ix, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        `CHK("rdata", {24'h00_0000, e}, rdata)
        `CHK("rresp", er, rresp)
    endtask : rd
    task automatic t_map();
        rd(nsi_pkg::IDX_PIN_EDGE, 8'h00, 2'h0);
        rd(nsi_pkg::IDX_RQ_HIGH, 8'h00, 2'h0);
        rd(nsi_pkg::IDX_STACK_LEVEL, 8'h07, 2'h0);
        wr(nsi_pkg::IDX_EN_LOW, 8'hff, 2'h0);
        rd(nsi_pkg::IDX_EN_LOW, 8'hf7, 2'h0);
        wr(nsi_pkg::IDX_EN_HIGH, 8'hff, 2'h0);
        rd(nsi_pkg::IDX_EN_HIGH, 8'h03, 2'h0);
        wr(nsi_pkg::IDX_PIN_EDGE, 8'hff, 2'h0);
        rd(nsi_pkg::IDX_PIN_EDGE, 8'h3f, 2'h0);
        wr(8'h10, 8'hff, nsi_pkg::RESP_SLVERR);
        rd(8'h10, 8'h00, nsi_pkg::RESP_SLVERR);
        $display("test map done");
    endtask : t_map
    task automatic t_events();
        wr(nsi_pkg::IDX_EN_LOW, 8'h00, 2'h0);
        wr(nsi_pkg::IDX_EN_HIGH, 8'h00, 2'h0);
        wr(nsi_pkg::IDX_STACK_LEVEL, 8'h87, 2'h0);
        @(posedge aclk);
        source_events <= 6'h3f;
        @(posedge aclk);
        source_events <= 6'h00;
        rd(nsi_pkg::IDX_RQ_LOW, 8'hf0, 2'h0);
        rd(nsi_pkg::IDX_RQ_HIGH, 8'h03, 2'h0);
        `CHK("in_service", 1'b0, in_service_q)
        wr(nsi_pkg::IDX_RQ_LOW, 8'h00, 2'h0);
        wr(nsi_pkg::IDX_RQ_HIGH, 8'h00, 2'h0);
        $display("test events done");
    endtask : t_events
    task automatic t_pins();
        wr(nsi_pkg::IDX_STACK_LEVEL, 8'h07, 2'h0);
        wr(nsi_pkg::IDX_EN_LOW, 8'h07, 2'h0);
        for (int c = 0; c < 4; c++)
            for (int p = 0; p < 3; p++)
            begin
                wr(nsi_pkg::IDX_PIN_EDGE, 8'(c << (2 * p)), 2'h0);
                external_pin[p] <= 1'b1;
                repeat (3) @(posedge aclk);
                rd(nsi_pkg::IDX_RQ_LOW, 8'((c % 2) << p), 2'h0);
                wr(nsi_pkg::IDX_RQ_LOW, 8'h00, 2'h0);
                external_pin[p] <= 1'b0;
                repeat (3) @(posedge aclk);
                rd(nsi_pkg::IDX_RQ_LOW, 8'((c / 2) << p), 2'h0);
                wr(nsi_pkg::IDX_RQ_LOW, 8'h00, 2'h0);
            end
        wr(nsi_pkg::IDX_EN_LOW, 8'h00, 2'h0);
        wr(nsi_pkg::IDX_PIN_EDGE, 8'h03, 2'h0);
        external_pin[0] <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(nsi_pkg::IDX_RQ_LOW, 8'h00, 2'h0);
        $display("test pins done");
    endtask : t_pins
    task automatic t_wake();
        wr(nsi_pkg::IDX_PIN_EDGE, 8'h02, 2'h0); // Pin 0 falling, pin 1 reserved
        wr(nsi_pkg::IDX_EN_LOW, 8'h03, 2'h0);
        wr(nsi_pkg::IDX_STACK_LEVEL, 8'h87, 2'h0);
        hold       <= 1'b1;
        sleep_mode <= 1'b1;
        external_pin[1] <= 1'b1;
        repeat (6) @(posedge aclk);
        `CHK("wakes", 0, wakes)
        external_pin[0] <= 1'b0;
        repeat (6) @(posedge aclk);
        `CHK("wakes", 1, wakes)
        rd(nsi_pkg::IDX_RQ_LOW, 8'h00, 2'h0);
        sleep_mode <= 1'b0;
        do @(posedge aclk); while (vector_load_q !== 1'b1);
        `CHK("pc", nsi_pkg::IRQ_VECTOR, pc_vector_q)
        rd(nsi_pkg::IDX_STACK_LEVEL, 8'h06, 2'h0);
        rd(nsi_pkg::IDX_RQ_LOW, 8'h01, 2'h0);
        wr(nsi_pkg::IDX_RQ_LOW, 8'h00, 2'h0);
        hold <= 1'b0;
        do @(posedge aclk); while (restore_q !== 1'b1);
        `CHK("in_service", 1'b0, in_service_q)
        rd(nsi_pkg::IDX_STACK_LEVEL, 8'h87, 2'h0);
        $display("test wake done");
    endtask : t_wake
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_map();
        t_events();
        t_pins();
        t_wake();
        print_verdict();
    end
endmodule : test_nine_source_interrupt_unit
